//--- rtl/rxmsd_detector.v
// Receive message start detector with input character FIFO
// Behaviour
// - A start is declared as soon as either start pattern matches; one alone suffices.
// - Pattern one spans five characters, first 0x6A and fifth 0x1C.
// - Characters two to four of pattern one are wildcards accepting any value.
// - On a pattern one match, end evaluation begins right after the fifth character.
// - Pattern two is any character followed directly by two characters equal to 0x6A.
// - On a pattern two match, end evaluation begins right after the second 0x6A.
// - The wildcard before the first 0x6A counts as part of the pattern two start.
`timescale 1ns/1ps
`include "rxmsd_regs.vh"

module rxmsd_detector #(
   parameter CHAR_W     = `RXMSD_CHAR_W,
   parameter FIFO_DEPTH = `RXMSD_FIFO_DEPTH,
   parameter FIFO_AW    = `RXMSD_FIFO_AW
) (
   input  wire              i_core_clk,
   input  wire              i_rst_b,
   input  wire              i_ce,
   input  wire [CHAR_W-1:0] i_rx_char,
   input  wire              i_rx_valid,
   output wire              o_rx_ready,
   input  wire              i_end_done,
   output reg               o_start_pulse,
   output reg               o_start_p1,
   output reg               o_start_p2,
   output reg  [2:0]        o_start_len,
   output reg               o_end_eval,
   output reg  [CHAR_W-1:0] o_body_char,
   output reg               o_body_valid
);

   // ---------------------------------------------------------------
   // Character buffer
   // ---------------------------------------------------------------
   wire [CHAR_W-1:0] ff_data;
   wire              ff_valid;
   wire              ff_ready;
   wire              take;

   rxmsd_fifo #(
      .WIDTH (CHAR_W),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .i_core_clk (i_core_clk),
      .i_rst_b    (i_rst_b),
      .i_ce       (i_ce),
      .i_wr_data  (i_rx_char),
      .i_wr_valid (i_rx_valid),
      .o_wr_ready (o_rx_ready),
      .o_rd_data  (ff_data),
      .o_rd_valid (ff_valid),
      .i_rd_ready (ff_ready)
   );

   // Hunting always drains; in end phase the end logic stalls nothing either,
   // but a pending completion holds the stream for one cycle so no character
   // is judged against a stale history.
   assign ff_ready = ~(o_end_eval & i_end_done);
   assign take     = ff_valid & ff_ready;

   // ---------------------------------------------------------------
   // Sliding history
   // ---------------------------------------------------------------
   reg [CHAR_W-1:0] hist_q [0:`RXMSD_HIST_LEN-1];
   reg [2:0]        fill_q;
   reg              state_q;
   reg              state_d;
   wire             p1_hit;
   wire             p2_hit;
   integer          k;

   // History index 0 is the newest character already accepted; the pattern
   // is judged with the incoming character as the newest element.
   assign p1_hit = (fill_q >= (`RXMSD_P1_LEN - 3'h1))
                 & (hist_q[3] == `RXMSD_P1_FIRST)
                 & (ff_data == `RXMSD_P1_FIFTH);
   assign p2_hit = (fill_q >= (`RXMSD_P2_LEN - 3'h1))
                 & (hist_q[0] == `RXMSD_P2_FIXED)
                 & (ff_data == `RXMSD_P2_FIXED);

   always @*
   begin
      state_d = state_q;
      case (state_q)
         `RXMSD_ST_HUNT:
         begin
            if (take && (p1_hit || p2_hit))
            begin
               state_d = `RXMSD_ST_END;
            end
         end
         `RXMSD_ST_END:
         begin
            if (i_end_done)
            begin
               state_d = `RXMSD_ST_HUNT;
            end
         end
         default:
         begin
            state_d = `RXMSD_ST_HUNT;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Sequential state
   // ---------------------------------------------------------------
   always @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_q       <= `RXMSD_ST_HUNT;
         fill_q        <= 3'h0;
         o_start_pulse <= 1'b0;
         o_start_p1    <= 1'b0;
         o_start_p2    <= 1'b0;
         o_start_len   <= 3'h0;
         o_end_eval    <= 1'b0;
         o_body_char   <= {CHAR_W{1'b0}};
         o_body_valid  <= 1'b0;
         for (k = 0; k < `RXMSD_HIST_LEN; k = k + 1)
         begin
            hist_q[k] <= {CHAR_W{1'b0}};
         end
      end
      else if (i_ce)
      begin
         state_q       <= state_d;
         o_start_pulse <= 1'b0;
         o_body_valid  <= 1'b0;
         o_end_eval    <= (state_d == `RXMSD_ST_END);
         if (take && state_q == `RXMSD_ST_HUNT)
         begin
            for (k = `RXMSD_HIST_LEN - 1; k > 0; k = k - 1)
            begin
               hist_q[k] <= hist_q[k-1];
            end
            hist_q[0] <= ff_data;
            if (fill_q != `RXMSD_P1_LEN)
            begin
               fill_q <= fill_q + 3'h1;
            end
            if (p1_hit || p2_hit)
            begin
               o_start_pulse <= 1'b1;
               o_start_p1    <= p1_hit;
               o_start_p2    <= p2_hit;
               // Longest pattern wins the length so the framer keeps all
               o_start_len   <= p1_hit ? `RXMSD_P1_LEN : `RXMSD_P2_LEN;
               fill_q        <= 3'h0;
            end
         end
         else if (take)
         begin
            // Characters after a start go to end evaluation
            o_body_char  <= ff_data;
            o_body_valid <= 1'b1;
         end
         if (state_q == `RXMSD_ST_END && i_end_done)
         begin
            fill_q <= 3'h0;
         end
      end
   end

endmodule // rxmsd_detector

//--- rtl/rxmsd_fifo.v
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps

module rxmsd_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             i_core_clk,
   input  wire             i_rst_b,
   input  wire             i_ce,
   input  wire [WIDTH-1:0] i_wr_data,
   input  wire             i_wr_valid,
   output wire             o_wr_ready,
   output reg  [WIDTH-1:0] o_rd_data,
   output wire             o_rd_valid,
   input  wire             i_rd_ready
);

   reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr_q;
   reg  [AW-1:0]    rd_ptr_q;
   reg  [AW:0]      count_q;
   reg              out_vld_q;
   wire             push;
   wire             pop_mem;
   wire             mem_empty;

   // ---------------------------------------------------------------
   // Storage plus one output register so read data leave a flop
   // ---------------------------------------------------------------
   assign mem_empty  = (count_q == {(AW+1){1'b0}});
   assign o_wr_ready = (count_q != DEPTH[AW:0]);
   assign o_rd_valid = out_vld_q;
   assign push       = i_wr_valid & o_wr_ready;
   assign pop_mem    = ~mem_empty & (~out_vld_q | i_rd_ready);

   always @(posedge i_core_clk)
   begin
      if (i_ce && push)
      begin
         mem_q[wr_ptr_q] <= i_wr_data;
      end
   end

   always @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         wr_ptr_q  <= {AW{1'b0}};
         rd_ptr_q  <= {AW{1'b0}};
         count_q   <= {(AW+1){1'b0}};
         out_vld_q <= 1'b0;
         o_rd_data <= {WIDTH{1'b0}};
      end
      else if (i_ce)
      begin
         if (push)
         begin
            wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop_mem)
         begin
            rd_ptr_q  <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            o_rd_data <= mem_q[rd_ptr_q];
            out_vld_q <= 1'b1;
         end
         else if (i_rd_ready)
         begin
            out_vld_q <= 1'b0;
         end
         if (push && !pop_mem)
         begin
            count_q <= count_q + {{AW{1'b0}}, 1'b1};
         end
         else if (!push && pop_mem)
         begin
            count_q <= count_q - {{AW{1'b0}}, 1'b1};
         end
      end
   end

endmodule // rxmsd_fifo

//--- rtl/rxmsd_regs.vh
// Constants for the receive message start detector
`ifndef RXMSD_REGS_VH
`define RXMSD_REGS_VH

// ---------------------------------------------------------------
// Start pattern characters
// ---------------------------------------------------------------
`define RXMSD_P1_FIRST     8'h6a
`define RXMSD_P1_FIFTH     8'h1c
`define RXMSD_P2_FIXED     8'h6a

// ---------------------------------------------------------------
// Geometry
// ---------------------------------------------------------------
`define RXMSD_CHAR_W       8
`define RXMSD_HIST_LEN     5
`define RXMSD_P1_LEN       3'h5
`define RXMSD_P2_LEN       3'h3
`define RXMSD_FIFO_DEPTH   16
`define RXMSD_FIFO_AW      4

// ---------------------------------------------------------------
// States
// ---------------------------------------------------------------
`define RXMSD_ST_HUNT      1'b0
`define RXMSD_ST_END       1'b1

`endif

//--- tb/rxmsd_detector_sva.sv
// Port checker for the message start detector
`timescale 1ns/1ps
module rxmsd_detector_sva (
   input logic       i_core_clk,
   input logic       i_rst_b,
   input logic       i_ce,
   input logic       i_end_done,
   input logic       o_start_pulse,
   input logic       o_start_p1,
   input logic       o_start_p2,
   input logic [2:0] o_start_len,
   input logic       o_end_eval,
   input logic       o_body_valid
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   sequence start_s; o_start_pulse && i_ce; endsequence
   sequence done_s; o_end_eval && i_end_done && i_ce; endsequence
   start_cause_a: assert property (start_s |-> o_start_p1 || o_start_p2)
      else $error("start without pattern");
   p1_len_a: assert property (start_s ##0 o_start_p1 |-> o_start_len == 3'h5)
      else $error("pattern one length wrong");
   p2_len_a: assert property (start_s ##0 !o_start_p1 |-> o_start_p2 && o_start_len == 3'h3)
      else $error("pattern two length wrong");
   eval_on_start_a: assert property (start_s |-> o_end_eval)
      else $error("end phase missing at start");
   eval_rise_a: assert property ($rose(o_end_eval) |-> o_start_pulse)
      else $error("end phase without start");
   pulse_once_a: assert property (start_s |=> !o_start_pulse)
      else $error("start pulse too long");
   body_in_end_a: assert property (o_body_valid |-> o_end_eval)
      else $error("body char while hunting");
   hunt_again_a: assert property (done_s |=> !o_end_eval [*2])
      else $error("end phase kept after done");
   frozen_a: assert property (!i_ce |=> $stable({o_end_eval, o_start_len}))
      else $error("state moved while disabled");
endmodule // rxmsd_detector_sva
bind rxmsd_detector rxmsd_detector_sva rxmsd_detector_sva_i (
   .i_core_clk    (i_core_clk),
   .i_rst_b       (i_rst_b),
   .i_ce          (i_ce),
   .i_end_done    (i_end_done),
   .o_start_pulse (o_start_pulse),
   .o_start_p1    (o_start_p1),
   .o_start_p2    (o_start_p2),
   .o_start_len   (o_start_len),
   .o_end_eval    (o_end_eval),
   .o_body_valid  (o_body_valid)
);

//--- tb/rxmsd_sender.sv
// Remote sender model feeding characters to the detector
`timescale 1ns/1ps
module rxmsd_sender (
   input  logic       i_core_clk,
   input  logic       i_ready,
   input  logic       i_ce,
   output logic [7:0] o_char,
   output logic       o_valid
);
   initial
   begin
      o_char = 8'h00;
      o_valid = 1'b0;
   end
   // Held until an enabled edge sees ready
   task send(input logic [7:0] c);
      @(negedge i_core_clk);
      o_valid = 1'b1;
      o_char = c;
      do @(posedge i_core_clk); while (!(i_ready && i_ce));
   endtask
   // Released line is inverted so a stale char is never mistaken
   task idle;
      @(negedge i_core_clk);
      o_valid = 1'b0;
      o_char = ~o_char;
   endtask
endmodule // rxmsd_sender

//--- tb/test_rx_message_start_detector.sv
// Self-checking bench for the message start detector
`timescale 1ns/1ps
module test_rx_message_start_detector;
   logic       clk, rst_b, ce, done, rdy, sp, p1w, p2w, ev, bv, rxv, p1, p2;
   logic [2:0] lw, len;
   logic [7:0] rxc, bc, body;
   int         n_errors, checks, n_start, n_body;
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   rxmsd_detector rxmsd_detector_i (.i_core_clk(clk), .i_rst_b(rst_b), .i_ce(ce),
      .i_rx_char(rxc), .i_rx_valid(rxv), .o_rx_ready(rdy), .i_end_done(done),
      .o_start_pulse(sp), .o_start_p1(p1w), .o_start_p2(p2w), .o_start_len(lw),
      .o_end_eval(ev), .o_body_char(bc), .o_body_valid(bv));
   rxmsd_sender rxmsd_sender_i (.i_core_clk(clk), .i_ready(rdy), .i_ce(ce), .o_char(rxc),
      .o_valid(rxv));
   always @(posedge clk)
   begin
      if (ce === 1'b1 && sp === 1'b1)
      begin
         n_start++;
         p1 = p1w;
         p2 = p2w;
         len = lw;
      end
      if (ce === 1'b1 && bv === 1'b1)
      begin
         n_body++;
         body = bc;
      end
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      if (got !== exp)
         n_errors++;
   endtask
   task settle;
      rxmsd_sender_i.idle();
      repeat (5) @(negedge clk);
   endtask
   task finish_msg;
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
      repeat (2) @(negedge clk);
      chk(ev, 1'b0);
   endtask
   task t_pat2;
      n_start = 0;
      n_body = 0;
      rxmsd_sender_i.send(8'h41);
      rxmsd_sender_i.send(8'h6a);
      rxmsd_sender_i.send(8'h6a);
      settle();
      chk(n_start, 1);
      chk({p1, p2, len}, 5'h0b);
      chk(ev, 1'b1);
      // Offer a character while disabled: nothing may move until enable returns
      ce = 1'b0;
      fork
         rxmsd_sender_i.send(8'h33);
         begin
            repeat (3) @(negedge clk);
            chk(n_body, 0);
            chk(rdy, 1'b1);
            ce = 1'b1;
         end
      join
      settle();
      chk(n_body, 1);
      chk(body, 8'h33);
      finish_msg();
      $display("test pattern two done");
   endtask
   task t_nowild;
      n_start = 0;
      rxmsd_sender_i.send(8'h6a);
      rxmsd_sender_i.send(8'h6a);
      rxmsd_sender_i.send(8'h1c);
      settle();
      chk(n_start, 0);
      $display("test no wildcard done");
   endtask
   task t_pat1;
      n_start = 0;
      rxmsd_sender_i.send(8'h6a);
      rxmsd_sender_i.send(8'h00);
      rxmsd_sender_i.send(8'hff);
      rxmsd_sender_i.send(8'h55);
      rxmsd_sender_i.send(8'h1c);
      settle();
      chk(n_start, 1);
      chk({p1, p2, len}, 5'h15);
      chk(ev, 1'b1);
      finish_msg();
      $display("test pattern one done");
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      // Generous bound: the tests need well under 200 cycles
      #(2000 * 25);
      n_errors++;
      end_of_test();
   end
   initial
   begin
      rst_b = 1'b0;
      ce = 1'b1;
      done = 1'b0;
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      t_pat2();
      t_nowild();
      t_pat1();
      end_of_test();
   end
endmodule // test_rx_message_start_detector
